// ### design/fmsp_regs.svh
// Control register map, field positions, reset values and timing counts of the serial port
`ifndef FMSP_REGS_SVH
`define FMSP_REGS_SVH
`define FMSP_ADDR_CTRL 8'h98
`define FMSP_ADDR_BUF 8'h99
`define FMSP_CTRL_RESET 8'h00
`define FMSP_BUF_RESET 8'h00
`define FMSP_BIT_MODE_HI 7
`define FMSP_BIT_MODE_LO 6
`define FMSP_BIT_FILTER 5
`define FMSP_BIT_RX_EN 4
`define FMSP_BIT_TX_B9 3
`define FMSP_BIT_RX_B9 2
`define FMSP_BIT_TX_DONE 1
`define FMSP_BIT_RX_DONE 0
`define FMSP_SHIFT_DIVISOR 12
`define FMSP_SHIFT_DIV_LAST 4'(`FMSP_SHIFT_DIVISOR - 1)
`define FMSP_SHIFT_DIV_HALF 4'(`FMSP_SHIFT_DIVISOR / 2)
`define FMSP_SHIFT_LAST_BIT 3'h7
`define FMSP_OVERSAMPLE 16
`define FMSP_FIX_DIV_SLOW 64
`define FMSP_FIX_DIV_FAST 32
`define FMSP_FIX_PRE_SLOW 2'(`FMSP_FIX_DIV_SLOW / `FMSP_OVERSAMPLE - 1)
`define FMSP_FIX_PRE_FAST 2'(`FMSP_FIX_DIV_FAST / `FMSP_OVERSAMPLE - 1)
`define FMSP_OVS_LAST 4'(`FMSP_OVERSAMPLE - 1)
`define FMSP_OVS_MID 4'(`FMSP_OVERSAMPLE / 2 - 1)
`define FMSP_LAST_IDX_8 4'h9
`define FMSP_LAST_IDX_9 4'hA
`define FMSP_NINTH_IDX 4'h9
`define FMSP_FIFO_WIDTH 9
`define FMSP_FIFO_DEPTH 4
`endif

// ### design/fmsp_pkg.sv
// Types shared by the serial port: modes, shift engine states and the state record
package fmsp_pkg;

    typedef enum logic [1:0] {
        FMSP_MODE_SHIFT = 2'b00,
        FMSP_MODE_ASYNC8 = 2'b01,
        FMSP_MODE_FIXED9 = 2'b10,
        FMSP_MODE_VAR9 = 2'b11
    } fmsp_mode_t;

    typedef enum logic [1:0] {
        FMSP_SH_IDLE = 2'b00,
        FMSP_SH_TX = 2'b01,
        FMSP_SH_RX = 2'b10
    } fmsp_shift_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] rx_buf;
        logic [2:0] rx_sync;
        logic rxd;
        logic rxd_prev;
        logic [1:0] fix_pre;
        logic t1_half;
        logic tx_busy;
        logic [3:0] tx_phase;
        logic [3:0] tx_idx;
        logic [9:0] tx_sh;
        logic txd;
        logic rx_busy;
        logic [3:0] rx_phase;
        logic [3:0] rx_idx;
        logic [7:0] rx_sh;
        logic rx_b9;
        fmsp_shift_t sh_state;
        logic [3:0] sh_div;
        logic [2:0] sh_idx;
        logic [7:0] sh_data;
        logic [7:0] rdata;
        logic tf2_sup;
        logic pin_out;
        logic data_out;
        logic data_oe;
    } fmsp_state_t;

endpackage : fmsp_pkg

// ### design/fmsp_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
module fmsp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [CW-1:0] count;
        logic full;
        logic empty;
    } fmsp_fifo_st_t;

    fmsp_fifo_st_t s_r;
    fmsp_fifo_st_t s_nxt;
    logic push;
    logic pop;

    // Full and empty are flops so ready and valid reach the ports glitch free
    assign in_ready_o = ~s_r.full;
    assign out_valid_o = ~s_r.empty;
    assign out_data_o = s_r.mem[s_r.rptr];
    assign push = in_valid_i & ~s_r.full;
    assign pop = out_ready_i & ~s_r.empty;

    // Pointer wrap handles depths that are not a power of two
    always_comb
    begin
        s_nxt = s_r;
        if (push)
        begin
            s_nxt.mem[s_r.wptr] = in_data_i;
            s_nxt.wptr = (s_r.wptr == AW'(DEPTH - 1)) ? '0 : s_r.wptr + AW'(1);
        end
        if (pop)
        begin
            s_nxt.rptr = (s_r.rptr == AW'(DEPTH - 1)) ? '0 : s_r.rptr + AW'(1);
        end
        s_nxt.count = s_r.count + CW'(push) - CW'(pop);
        s_nxt.full = (s_nxt.count == CW'(DEPTH));
        s_nxt.empty = (s_nxt.count == '0);
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_r <= '{mem: '0, wptr: '0, rptr: '0, count: '0, full: 1'b0, empty: 1'b1};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule : fmsp_fifo

// ### design/fmsp_serial_port.sv
// Four mode serial port: control and buffer registers, shift mode and asynchronous engines
`include "fmsp_regs.svh"

module fmsp_serial_port (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic baud_doubler_i,
    input wire logic tx_baud_from_timer2_i,
    input wire logic rx_baud_from_timer2_i,
    input wire logic timer1_ovf_i,
    input wire logic timer2_ovf_i,
    input wire logic serial_data_i,
    output logic serial_data_o,
    output logic serial_data_oe_o,
    output logic serial_out_o,
    output logic timer2_flag_suppress_o,
    output logic tx_room_o
);

    logic [1:0] rst_sync_r;
    logic rst_n;
    fmsp_pkg::fmsp_state_t s_r;
    fmsp_pkg::fmsp_state_t s_nxt;
    fmsp_pkg::fmsp_mode_t mode;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [`FMSP_FIFO_WIDTH-1:0] fifo_in_data;
    logic [`FMSP_FIFO_WIDTH-1:0] fifo_out_data;
    logic fix_tick;
    logic t1_tick;
    logic tx_tick;
    logic rx_tick;
    logic rx_accept;
    logic rx_bit9;

    // Last frame bit index: stop bit follows bit 8 or the ninth bit
    function automatic logic [3:0] last_idx(input fmsp_pkg::fmsp_mode_t m);
        last_idx = (m == fmsp_pkg::FMSP_MODE_ASYNC8) ? `FMSP_LAST_IDX_8 : `FMSP_LAST_IDX_9;
    endfunction : last_idx

    // Reset release is synchronised; assertion stays asynchronous
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_sync_r <= 2'h0;
        end
        else
        begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Mode comes straight from the two top control bits
    assign mode = fmsp_pkg::fmsp_mode_t'({s_r.ctrl[`FMSP_BIT_MODE_HI],
                                          s_r.ctrl[`FMSP_BIT_MODE_LO]});

    // Transmit words carry the ninth bit as it stood at the write
    assign fifo_in_valid = sfr_wr_i & (sfr_addr_i == `FMSP_ADDR_BUF);
    assign fifo_in_data = {s_r.ctrl[`FMSP_BIT_TX_B9], sfr_wdata_i};

    fmsp_fifo #(
        .WIDTH(`FMSP_FIFO_WIDTH),
        .DEPTH(`FMSP_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // Sixteen-phase ticks; Timer 1 halves its overflow rate unless doubled
    assign fix_tick = (s_r.fix_pre == 2'h0);
    assign t1_tick = timer1_ovf_i & (baud_doubler_i | s_r.t1_half);
    // Each Timer 2 overflow is one sixteenth of a bit
    assign tx_tick = (mode == fmsp_pkg::FMSP_MODE_FIXED9) ? fix_tick :
                     (tx_baud_from_timer2_i ? timer2_ovf_i : t1_tick);
    assign rx_tick = (mode == fmsp_pkg::FMSP_MODE_FIXED9) ? fix_tick :
                     (rx_baud_from_timer2_i ? timer2_ovf_i : t1_tick);

    // Ninth bit is the stop bit in the 8-bit mode, the data ninth bit otherwise
    assign rx_bit9 = (mode == fmsp_pkg::FMSP_MODE_ASYNC8) ? s_r.rxd : s_r.rx_b9;
    // Accept only into an empty buffer and past the address filter
    assign rx_accept = ~s_r.ctrl[`FMSP_BIT_RX_DONE] &
                       (~s_r.ctrl[`FMSP_BIT_FILTER] | rx_bit9);

    // Handshake to the transmit FIFO: pop when an engine takes a word
    always_comb
    begin
        fifo_out_ready = 1'b0;
        if (mode == fmsp_pkg::FMSP_MODE_SHIFT)
        begin
            fifo_out_ready = fifo_out_valid & (s_r.sh_state == fmsp_pkg::FMSP_SH_IDLE);
        end
        else
        begin
            fifo_out_ready = fifo_out_valid & ~s_r.tx_busy & tx_tick;
        end
    end

    // All next-state logic; hardware sets are applied after software writes so they win
    always_comb
    begin
        s_nxt = s_r;

        // Software write of the control register and reads of either register
        if (sfr_wr_i && (sfr_addr_i == `FMSP_ADDR_CTRL))
        begin
            s_nxt.ctrl = sfr_wdata_i;
        end
        if (sfr_rd_i)
        begin
            if (sfr_addr_i == `FMSP_ADDR_CTRL)
            begin
                s_nxt.rdata = s_r.ctrl;
            end
            else if (sfr_addr_i == `FMSP_ADDR_BUF)
            begin
                s_nxt.rdata = s_r.rx_buf;
            end
            else
            begin
                s_nxt.rdata = 8'h00;
            end
        end

        // Three-flop pin filter; the level moves only when the last two agree
        s_nxt.rx_sync = {s_r.rx_sync[1:0], serial_data_i};
        if (s_r.rx_sync[1] == s_r.rx_sync[2])
        begin
            s_nxt.rxd = s_r.rx_sync[2];
        end
        s_nxt.rxd_prev = s_r.rxd;

        // Fixed-rate prescaler and Timer 1 overflow halver
        if (fix_tick)
        begin
            s_nxt.fix_pre = baud_doubler_i ? `FMSP_FIX_PRE_FAST : `FMSP_FIX_PRE_SLOW;
        end
        else
        begin
            s_nxt.fix_pre = s_r.fix_pre - 2'h1;
        end
        if (timer1_ovf_i)
        begin
            s_nxt.t1_half = ~s_r.t1_half;
        end

        // Either Timer 2 select tells the timer to keep its overflow flag quiet
        s_nxt.tf2_sup = tx_baud_from_timer2_i | rx_baud_from_timer2_i;

        if (mode == fmsp_pkg::FMSP_MODE_SHIFT)
        begin
            // Shift mode: one engine, twelve clocks per bit, clock low then high
            unique case (s_r.sh_state)
                fmsp_pkg::FMSP_SH_IDLE:
                begin
                    s_nxt.sh_div = 4'h0;
                    s_nxt.sh_idx = 3'h0;
                    if (fifo_out_valid)
                    begin
                        s_nxt.sh_state = fmsp_pkg::FMSP_SH_TX;
                        s_nxt.sh_data = fifo_out_data[7:0];
                    end
                    else if (s_r.ctrl[`FMSP_BIT_RX_EN] && !s_r.ctrl[`FMSP_BIT_RX_DONE])
                    begin
                        s_nxt.sh_state = fmsp_pkg::FMSP_SH_RX;
                    end
                end
                fmsp_pkg::FMSP_SH_TX, fmsp_pkg::FMSP_SH_RX:
                begin
                    s_nxt.sh_div = s_r.sh_div + 4'h1;
                    // Sample on the rising edge of the shift clock
                    if ((s_r.sh_state == fmsp_pkg::FMSP_SH_RX) &&
                        (s_r.sh_div == `FMSP_SHIFT_DIV_HALF))
                    begin
                        s_nxt.sh_data = {s_r.rxd, s_r.sh_data[7:1]};
                    end
                    if (s_r.sh_div == `FMSP_SHIFT_DIV_LAST)
                    begin
                        s_nxt.sh_div = 4'h0;
                        s_nxt.sh_idx = s_r.sh_idx + 3'h1;
                        if (s_r.sh_state == fmsp_pkg::FMSP_SH_TX)
                        begin
                            s_nxt.sh_data = {1'b0, s_r.sh_data[7:1]};
                        end
                        if (s_r.sh_idx == `FMSP_SHIFT_LAST_BIT)
                        begin
                            s_nxt.sh_state = fmsp_pkg::FMSP_SH_IDLE;
                            if (s_r.sh_state == fmsp_pkg::FMSP_SH_TX)
                            begin
                                s_nxt.ctrl[`FMSP_BIT_TX_DONE] = 1'b1;
                            end
                            else
                            begin
                                s_nxt.rx_buf = s_r.sh_data;
                                s_nxt.ctrl[`FMSP_BIT_RX_DONE] = 1'b1;
                            end
                        end
                    end
                end
                default:
                begin
                    s_nxt.sh_state = fmsp_pkg::FMSP_SH_IDLE;
                end
            endcase
        end
        else
        begin
            // Transmitter: a word is taken on a baud tick and the start bit goes out
            if (!s_r.tx_busy)
            begin
                if (fifo_out_ready)
                begin
                    s_nxt.tx_busy = 1'b1;
                    s_nxt.tx_phase = 4'h0;
                    s_nxt.tx_idx = 4'h0;
                    s_nxt.txd = 1'b0;
                    if (mode == fmsp_pkg::FMSP_MODE_ASYNC8)
                    begin
                        s_nxt.tx_sh = {2'b11, fifo_out_data[7:0]};
                    end
                    else
                    begin
                        s_nxt.tx_sh = {1'b1, fifo_out_data};
                    end
                end
            end
            else if (tx_tick)
            begin
                s_nxt.tx_phase = s_r.tx_phase + 4'h1;
                if (s_r.tx_phase == `FMSP_OVS_LAST)
                begin
                    if (s_r.tx_idx == last_idx(mode))
                    begin
                        s_nxt.tx_busy = 1'b0;
                        s_nxt.txd = 1'b1;
                    end
                    else
                    begin
                        // LSB first, ones fill in behind so the line ends high
                        s_nxt.tx_idx = s_r.tx_idx + 4'h1;
                        s_nxt.txd = s_r.tx_sh[0];
                        s_nxt.tx_sh = {1'b1, s_r.tx_sh[9:1]};
                        if ((s_r.tx_idx + 4'h1) == last_idx(mode))
                        begin
                            s_nxt.ctrl[`FMSP_BIT_TX_DONE] = 1'b1;
                        end
                    end
                end
            end

            // Receiver runs beside the transmitter, independent of the buffer
            if (!s_r.rx_busy)
            begin
                if (s_r.ctrl[`FMSP_BIT_RX_EN] && s_r.rxd_prev && !s_r.rxd)
                begin
                    s_nxt.rx_busy = 1'b1;
                    s_nxt.rx_phase = 4'h0;
                    s_nxt.rx_idx = 4'h0;
                end
            end
            else if (rx_tick)
            begin
                s_nxt.rx_phase = s_r.rx_phase + 4'h1;
                if (s_r.rx_phase == `FMSP_OVS_LAST)
                begin
                    s_nxt.rx_idx = s_r.rx_idx + 4'h1;
                end
                if (s_r.rx_phase == `FMSP_OVS_MID)
                begin
                    if (s_r.rx_idx == 4'h0)
                    begin
                        // A glitch that is high again at mid-start is no frame
                        s_nxt.rx_busy = s_r.rxd ? 1'b0 : 1'b1;
                    end
                    else if (s_r.rx_idx == last_idx(mode))
                    begin
                        // Mid stop bit: ends the frame, so a new start edge is seen early
                        s_nxt.rx_busy = 1'b0;
                        if (rx_accept)
                        begin
                            s_nxt.rx_buf = s_r.rx_sh;
                            s_nxt.ctrl[`FMSP_BIT_RX_B9] = rx_bit9;
                            s_nxt.ctrl[`FMSP_BIT_RX_DONE] = 1'b1;
                        end
                    end
                    else if (s_r.rx_idx == `FMSP_NINTH_IDX)
                    begin
                        s_nxt.rx_b9 = s_r.rxd;
                    end
                    else
                    begin
                        s_nxt.rx_sh = {s_r.rxd, s_r.rx_sh[7:1]};
                    end
                end
            end
        end

        // Pin drivers, registered from the next state
        if (mode == fmsp_pkg::FMSP_MODE_SHIFT)
        begin
            s_nxt.pin_out = (s_nxt.sh_state == fmsp_pkg::FMSP_SH_IDLE) ? 1'b1 :
                            (s_nxt.sh_div >= `FMSP_SHIFT_DIV_HALF);
            s_nxt.data_oe = (s_nxt.sh_state == fmsp_pkg::FMSP_SH_TX);
            // Released data pin shows its idle high, not leftover shift bits
            s_nxt.data_out = s_nxt.data_oe ? s_nxt.sh_data[0] : 1'b1;
        end
        else
        begin
            s_nxt.pin_out = s_nxt.txd;
            s_nxt.data_oe = 1'b0;
            s_nxt.data_out = 1'b1;
        end
    end

    // Single state register; pins idle high and undriven after reset
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
            s_r.ctrl <= `FMSP_CTRL_RESET;
            s_r.rx_buf <= `FMSP_BUF_RESET;
            s_r.rx_sync <= 3'h7;
            s_r.rxd <= 1'b1;
            s_r.rxd_prev <= 1'b1;
            s_r.tx_sh <= 10'h3FF;
            s_r.txd <= 1'b1;
            s_r.sh_state <= fmsp_pkg::FMSP_SH_IDLE;
            s_r.pin_out <= 1'b1;
            s_r.data_out <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flops
    assign sfr_rdata_o = s_r.rdata;
    assign serial_data_o = s_r.data_out;
    assign serial_data_oe_o = s_r.data_oe;
    assign serial_out_o = s_r.pin_out;
    assign timer2_flag_suppress_o = s_r.tf2_sup;
    assign tx_room_o = fifo_in_ready;

endmodule : fmsp_serial_port

// ### dv/fmsp_serial_port_asserts.sv
// Port-level assertions for the four mode serial port
module fmsp_serial_port_asserts (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic baud_doubler_i,
    input wire logic serial_data_o,
    input wire logic serial_data_oe_o,
    input wire logic serial_out_o
);
    logic [4:0] ctrl_r;
    logic [3:0] pulse_r;
    logic [8:0] low_r;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    // Mirror of software-owned control bits, shift pulse count and low run length
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ctrl_r <= 5'h00;
            pulse_r <= 4'h0;
            low_r <= 9'h000;
        end
        else
        begin
            if (sfr_wr_i && sfr_addr_i == 8'h98)
                ctrl_r <= sfr_wdata_i[7:3];
            if ($rose(serial_data_oe_o))
                pulse_r <= {3'h0, $fell(serial_out_o)};
            else if ($fell(serial_out_o))
                pulse_r <= pulse_r + 4'h1;
            low_r <= serial_out_o ? 9'h000 : low_r + 9'h001;
        end
    end

    a_unmapped_zero: assert property (
        sfr_rd_i && sfr_addr_i != 8'h98 && sfr_addr_i != 8'h99 |=> sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (
        !sfr_rd_i |=> $stable(sfr_rdata_o))
        else $error("read data moved without a read");
    a_ctrl_readback: assert property (
        sfr_rd_i && !sfr_wr_i && sfr_addr_i == 8'h98 |=> sfr_rdata_o[7:3] == ctrl_r)
        else $error("control read back differs");
    a_oe_shift_only: assert property (
        serial_data_oe_o |-> ctrl_r[4:3] == 2'b00)
        else $error("data pin driven outside shift mode");
    a_data_released: assert property (
        !serial_data_oe_o |-> serial_data_o)
        else $error("data output not high when released");
    a_shift_clock: assert property (
        $fell(serial_out_o) && ctrl_r[4:3] == 2'b00 |-> !serial_out_o [*6] ##1 serial_out_o)
        else $error("shift clock low phase not six cycles");
    a_eight_pulses: assert property (
        $fell(serial_data_oe_o) |-> pulse_r == 4'h8)
        else $error("shift transmit not eight clock pulses");
    a_fixed_rate: assert property (
        $rose(serial_out_o) && ctrl_r[4:3] == 2'b10
        |-> (low_r % (baud_doubler_i ? 9'd32 : 9'd64)) == 9'h000)
        else $error("fixed rate bit length wrong");
endmodule : fmsp_serial_port_asserts

bind fmsp_serial_port fmsp_serial_port_asserts u_chk (.*);

// ### dv/fmsp_remote_node.sv
// Remote serial node: frames words onto the receive line and decodes the transmit line
module fmsp_remote_node #(
    parameter int BIT = 32
) (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line_o = 1'b1;

    // Start low, data LSB first, ninth bit if asked, stop; line rests high afterwards
    task automatic send(input logic [8:0] d, input logic nine, input logic stp);
        logic [10:0] f;
        f = nine ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
        for (int i = 0; i < (nine ? 11 : 10); i++)
        begin
            @(posedge clk_i);
            line_o <= f[i];
            repeat (BIT - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        line_o <= 1'b1;
    endtask : send

    // Samples mid-bit so the device's edge placement never races the sample
    task automatic recv(input logic nine, output logic [8:0] d, output logic stp);
        d = 9'h000;
        @(negedge line_i);
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < (nine ? 9 : 8); i++)
        begin
            repeat (BIT) @(posedge clk_i);
            d[i] = line_i;
        end
        repeat (BIT) @(posedge clk_i);
        stp = line_i;
    endtask : recv
endmodule : fmsp_remote_node

// ### dv/fmsp_serial_port_tb_top.sv
// Self-checking bench: registers, async frames both ways, overrun, shift mode, FIFO
module fmsp_serial_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] ctrl;
        logic t2;
        logic [8:0] rx;
        logic stop;
        logic flag;
    } fmsp_row_t;
    // Control, Timer 2 select, word sent in, its stop bit, receive flag expected
    fmsp_row_t rows [6] = '{
        '{8'h98, 1'b0, 9'h15A, 1'b1, 1'b1},
        '{8'hF0, 1'b1, 9'h0A5, 1'b1, 1'b0},
        '{8'hF8, 1'b0, 9'h13C, 1'b1, 1'b1},
        '{8'h50, 1'b1, 9'h0C3, 1'b1, 1'b1},
        '{8'h70, 1'b0, 9'h099, 1'b0, 1'b0},
        '{8'h40, 1'b0, 9'h066, 1'b1, 1'b0}};
    localparam logic [7:0] PAT = 8'hC5;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic t2 = 1'b0;
    logic t1_ovf = 1'b0;
    logic t2_ovf = 1'b0;
    logic use_sh = 1'b0;
    logic sh_bit = 1'b1;
    logic [7:0] rdata;
    logic d_out, d_oe, s_out, sup, room, node_tx, pin;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;

    // Shared data pin: device when enabled, else the shift stimulus or the node
    assign pin = d_oe ? d_out : (use_sh ? sh_bit : node_tx);
    always #20 clk_i = ~clk_i;

    fmsp_serial_port uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .sfr_addr_i(addr),
        .sfr_wr_i(wr_s), .sfr_rd_i(rd_s), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
        .baud_doubler_i(1'b1), .tx_baud_from_timer2_i(t2), .rx_baud_from_timer2_i(t2),
        .timer1_ovf_i(t1_ovf), .timer2_ovf_i(t2_ovf), .serial_data_i(pin),
        .serial_data_o(d_out), .serial_data_oe_o(d_oe), .serial_out_o(s_out),
        .timer2_flag_suppress_o(sup), .tx_room_o(room));
    fmsp_remote_node #(.BIT(32)) node (.clk_i(clk_i), .line_i(s_out), .line_o(node_tx));

    // Overflow pulses every two clocks give 32 clocks a bit; counter cuts a hang
    always @(posedge clk_i)
    begin
        t1_ovf <= ~t1_ovf;
        t2_ovf <= t1_ovf;
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_errors++;
            close_out();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk_i);
        wr_s <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_i);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    initial
    begin
        logic [7:0] d;
        logic [7:0] last;
        logic [8:0] got;
        logic stp;
        logic m9;
        fmsp_row_t r;
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        last = 8'h00;
        // Both frames run at once: device sends the inverse while it receives
        foreach (rows[i])
        begin
            r = rows[i];
            m9 = r.ctrl[7];
            t2 <= r.t2;
            wr(8'h98, r.ctrl);
            chk("suppress", {8'h00, r.t2}, {8'h00, sup});
            fork
                wr(8'h99, ~r.rx[7:0]);
                node.recv(m9, got, stp);
                node.send(r.rx, m9, r.stop);
            join
            chk("tx word", {m9 & r.ctrl[3], ~r.rx[7:0]}, got);
            chk("tx stop", 9'h001, {8'h00, stp});
            if (r.flag)
                last = r.rx[7:0];
            rd(8'h99, d);
            chk("rx buf", {1'b0, last}, {1'b0, d});
            rd(8'h98, d);
            chk("ctrl", {2'b00, r.ctrl[7:3], 1'b1, r.flag}, {2'b00, d[7:3], d[1:0]});
            if (r.flag)
                chk("rx ninth", {8'h00, m9 ? r.rx[8] : r.stop}, {8'h00, d[2]});
            wr(8'h98, r.ctrl);
        end
        $display("test rows done");
        // Second word completes while the first is unread and is dropped
        wr(8'h98, 8'h90);
        node.send(9'h011, 1'b1, 1'b1);
        node.send(9'h022, 1'b1, 1'b1);
        rd(8'h99, d);
        chk("overrun keep", 9'h011, {1'b0, d});
        $display("test overrun done");
        // A short low pulse on the data pin is no start bit: nothing lands
        wr(8'h98, 8'h90);
        use_sh <= 1'b1;
        sh_bit <= 1'b0;
        repeat (8) @(posedge clk_i);
        sh_bit <= 1'b1;
        repeat (400) @(posedge clk_i);
        rd(8'h98, d);
        chk("glitch start", 9'h090, {1'b0, d});
        $display("test glitch done");
        // Shift mode out on the data pin, then in against the emitted clock
        wr(8'h98, 8'h00);
        wr(8'h99, 8'h96);
        for (int k = 0; k < 8; k++)
        begin
            @(posedge s_out);
            d[k] = d_out;
        end
        chk("shift out", 9'h096, {1'b0, d});
        repeat (12) @(posedge clk_i);
        rd(8'h98, d);
        chk("shift tx done", 9'h001, {8'h00, d[1]});
        use_sh <= 1'b1;
        fork
            wr(8'h98, 8'h10);
            for (int k = 0; k < 8; k++)
            begin
                @(negedge s_out);
                @(posedge clk_i);
                sh_bit <= PAT[k];
            end
        join
        repeat (12) @(posedge clk_i);
        rd(8'h99, d);
        chk("shift in", {1'b0, PAT}, {1'b0, d});
        rd(8'h98, d);
        chk("shift rx done", 9'h001, {8'h00, d[0]});
        $display("test shift done");
        // Six back-to-back writes: transmitter takes one, FIFO four, the sixth is refused
        use_sh <= 1'b0;
        wr(8'h98, 8'h88);
        fork
            begin
                for (int k = 0; k < 6; k++)
                    wr(8'h99, 8'h30 + 8'(k));
                #1 chk("room full", 9'h000, {8'h00, room});
            end
            for (int k = 0; k < 5; k++)
            begin
                node.recv(1'b1, got, stp);
                chk("fifo order", {1'b1, 8'h30 + 8'(k)}, got);
            end
        join
        chk("room empty", 9'h001, {8'h00, room});
        $display("test fifo done");
        // Reset again in mid-run: control returns to its reset value
        arst_n_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        wr(8'h9A, 8'hFF);
        rd(8'h98, d);
        chk("ctrl reset", 9'h000, {1'b0, d});
        rd(8'h9A, d);
        chk("unmapped", 9'h000, {1'b0, d});
        $display("test reset done");
        close_out();
    end
endmodule : fmsp_serial_port_tb_top
